/* logic/gsc_pkg.sv */
package gsc_pkg;

    // time base
    localparam int CLK_HZ = 50_000_000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
    localparam int TICKS_PER_S = 1_000_000 / TICK_US;

    // times as printed, in their own units
    localparam int HOLD_S = 3;
    localparam int START_S = 4;
    localparam int AUTO_ZERO_S = 4;
    localparam int STABLE_S = 30;
    localparam int TIMEOUT_MIN = 12;
    localparam int DEBOUNCE_MS = 20;
    localparam int BLINK_MS = 250;

    // the same times as counts of ticks
    localparam int TMR_W = 20;
    localparam logic [TMR_W-1:0] HOLD_TICKS = TMR_W'(HOLD_S * TICKS_PER_S);
    localparam logic [TMR_W-1:0] START_TICKS = TMR_W'(START_S * TICKS_PER_S);
    localparam logic [TMR_W-1:0] AUTO_ZERO_TICKS = TMR_W'(AUTO_ZERO_S * TICKS_PER_S);
    localparam logic [TMR_W-1:0] STABLE_TICKS = TMR_W'(STABLE_S * TICKS_PER_S);
    localparam logic [TMR_W-1:0] TIMEOUT_TICKS = TMR_W'(TIMEOUT_MIN * 60 * TICKS_PER_S);
    localparam logic [7:0] DEBOUNCE_TICKS = 8'(DEBOUNCE_MS * 1000 / TICK_US);
    localparam logic [7:0] BLINK_TICKS = 8'(BLINK_MS * 1000 / TICK_US);

    // analog input
    localparam int ADC_W = 12;
    localparam int THRESH_PCT = 4;
    localparam logic [ADC_W-1:0] FULL_SCALE = 12'hFFF;
    localparam logic [ADC_W-1:0] LOW_LEVEL = ADC_W'(4095 * THRESH_PCT / 100);
    localparam logic [ADC_W-1:0] STABLE_BAND = 12'h010;
    localparam logic [ADC_W-1:0] ZERO_REF_RST = 12'h000;
    localparam logic [ADC_W-1:0] SPAN_REF_RST = 12'hFFF;

    // calibration log
    localparam int LOG_AW = 3;
    localparam logic [LOG_AW-1:0] LOG_FIRST = 3'h0;

    typedef enum logic [1:0] {
        GSC_LOG_ZERO,
        GSC_LOG_SPAN,
        GSC_LOG_ABORT
    } gsc_log_kind_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT_ZERO,
        ST_SPAN_WAIT,
        ST_FINISH_WAIT,
        ST_AUTO_ZERO,
        ST_AUTO_GAS,
        ST_AUTO_FALL,
        ST_ABORT
    } gsc_state_t;

endpackage

/* logic/gsc_sw_if.sv */
`timescale 1ns/10ps
interface gsc_sw_if;
    logic tick;
    logic blink;
    logic reed;
    logic repl_press;

    modport timebase (output tick, output blink);
    modport filter (input tick, output reed, output repl_press);
    modport core (input tick, input blink, input reed, input repl_press);
endinterface

/* logic/gsc_timebase.sv */
`timescale 1ns/10ps
module gsc_timebase #(
    parameter int TICK_CYCLES = gsc_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    // time base out
    gsc_sw_if.timebase sw
);

    logic [31:0] pre;
    logic [7:0] blink_cnt;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pre <= 32'h0;
            sw.tick <= 1'b0;
        end else if (clk_en) begin
            sw.tick <= (pre == 32'(TICK_CYCLES - 1));
            if (pre == 32'(TICK_CYCLES - 1)) begin
                pre <= 32'h0;
            end else begin
                pre <= pre + 32'h1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            blink_cnt <= 8'h00;
            sw.blink <= 1'b0;
        end else if (clk_en && sw.tick) begin
            if (blink_cnt == gsc_pkg::BLINK_TICKS - 8'h01) begin
                blink_cnt <= 8'h00;
                sw.blink <= ~sw.blink;
            end else begin
                blink_cnt <= blink_cnt + 8'h01;
            end
        end
    end

endmodule // gsc_timebase

/* logic/gsc_switch_filter.sv */
`timescale 1ns/10ps
module gsc_switch_filter (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    // switch pins, low while closed
    input wire logic reed_closed_n,
    input wire logic repl_pressed_n,
    // filtered switches
    gsc_sw_if.filter sw
);

    logic [1:0] pin_n;
    logic [1:0] meta;
    logic [1:0] sync;
    logic [1:0] stable;
    logic repl_q;

    assign pin_n = {repl_pressed_n, reed_closed_n};

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_sw
            logic [7:0] cnt;
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    meta[i] <= 1'b0;
                    sync[i] <= 1'b0;
                end else if (clk_en) begin
                    meta[i] <= ~pin_n[i];
                    sync[i] <= meta[i];
                end
            end
            // level must differ for the whole window before it is taken
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    cnt <= 8'h00;
                    stable[i] <= 1'b0;
                end else if (clk_en) begin
                    if (sync[i] == stable[i]) begin
                        cnt <= 8'h00;
                    end else if (sw.tick) begin
                        if (cnt == gsc_pkg::DEBOUNCE_TICKS - 8'h01) begin
                            cnt <= 8'h00;
                            stable[i] <= sync[i];
                        end else begin
                            cnt <= cnt + 8'h01;
                        end
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            repl_q <= 1'b0;
            sw.reed <= 1'b0;
            sw.repl_press <= 1'b0;
        end else if (clk_en) begin
            repl_q <= stable[1];
            sw.reed <= stable[0];
            sw.repl_press <= stable[1] & ~repl_q;
        end
    end

endmodule // gsc_switch_filter

/* logic/gsc_calib_seq.sv */
// How it works
// - timeout before completion restores old coefficients, flashes red, logs an abort
// - manual timeout also restores, logs abort and flashes the calibrate LED
// - manual mode outside a replacement sequence: red LED blinks while the reed switch is closed
// - manual mode: reed held the hold time enters await-zero, calibrate LED blinks
// - await-zero: reed held the hold time logs, stores zero, calibrate LED steady
// - after zero capture the calibrate LED blinks while input is more than the low level above zero
// - reed held the hold time after zero logs, stores span, LED steady
// - next reed activation after span ends calibration, calibrate LED off
// - replacement press starts replacement sequence, calibrate LED flashes for zero
// - replacement zero writes log position zero before zero reference changes
// - replacement span writes log first register, then span reference changes
// - replacement press mid-run aborts it and restarts at await-zero
// - module reset aborts any replacement sequence
// - operator holds reed the start time; red flashes the indication time
// - automatic mode logs and captures zero after the capture interval, LED steady
// - automatic mode flashes calibrate LED once input shows gas
// - automatic span captured and logged after input stable for the interval
// - after automatic span wait for input below threshold, then finish, LED off
// - replacement sequence suppresses the zero-input fault indication
`timescale 1ns/10ps
module gsc_calib_seq #(
    parameter int TICK_CYCLES = gsc_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    // operator switches and mode
    input wire logic reed_closed_n,
    input wire logic repl_pressed_n,
    input wire logic auto_mode,
    // digitised sensor loop
    input wire logic [gsc_pkg::ADC_W-1:0] sensor_value,
    // indicators
    output logic cal_led,
    output logic red_led,
    output logic fault_suppress,
    output logic cal_active,
    // coefficients
    output logic [gsc_pkg::ADC_W-1:0] zero_ref,
    output logic [gsc_pkg::ADC_W-1:0] span_ref,
    // calibration log write port
    output logic log_wr,
    output logic [gsc_pkg::LOG_AW-1:0] log_addr,
    output gsc_pkg::gsc_log_kind_t log_kind,
    output logic [gsc_pkg::ADC_W-1:0] log_data
);

    gsc_sw_if sw();

    gsc_timebase #(.TICK_CYCLES(TICK_CYCLES)) u_timebase (
        .ref_clk(ref_clk),
        .reset(reset),
        .clk_en(clk_en),
        .sw(sw)
    );

    gsc_switch_filter u_filter (
        .ref_clk(ref_clk),
        .reset(reset),
        .clk_en(clk_en),
        .reed_closed_n(reed_closed_n),
        .repl_pressed_n(repl_pressed_n),
        .sw(sw)
    );

    gsc_pkg::gsc_state_t state;
    logic repl_mode;
    logic reed_q;
    logic [gsc_pkg::TMR_W-1:0] hold_cnt;
    logic [gsc_pkg::TMR_W-1:0] step_cnt;
    logic [gsc_pkg::TMR_W-1:0] stable_cnt;
    logic [gsc_pkg::TMR_W-1:0] to_cnt;
    logic [gsc_pkg::ADC_W-1:0] anchor;
    logic [gsc_pkg::ADC_W-1:0] saved_zero;
    logic [gsc_pkg::ADC_W-1:0] saved_span;
    logic [gsc_pkg::ADC_W-1:0] above;
    logic [gsc_pkg::ADC_W-1:0] drift;
    logic [gsc_pkg::LOG_AW-1:0] log_ptr;
    logic pend_zero;
    logic pend_span;

    logic tick;
    logic blink;
    logic reed;
    logic repl_press;
    logic reed_rise;
    logic hold_evt;
    logic start_evt;
    logic gas_seen;
    logic below_low;
    logic timed;
    logic timeout_hit;
    logic start_man;
    logic start_auto;
    logic cap_zero;
    logic cap_span;

    assign tick = sw.tick;
    assign blink = sw.blink;
    assign reed = sw.reed;
    assign repl_press = sw.repl_press;
    assign reed_rise = reed & ~reed_q;

    // closure timing
    assign hold_evt = reed && tick && hold_cnt == gsc_pkg::HOLD_TICKS - 20'h1;
    assign start_evt = reed && tick && hold_cnt == gsc_pkg::START_TICKS - 20'h1;

    // input measured against the zero reference, drift against the anchor
    assign above = (sensor_value > zero_ref) ? sensor_value - zero_ref : 12'h000;
    assign drift = (sensor_value > anchor) ? sensor_value - anchor : anchor - sensor_value;
    assign gas_seen = above > gsc_pkg::LOW_LEVEL;
    assign below_low = above < gsc_pkg::LOW_LEVEL;

    // replacement runs are never timed out
    assign timed = state != gsc_pkg::ST_IDLE && state != gsc_pkg::ST_ABORT && !repl_mode;
    assign timeout_hit = timed && tick && to_cnt == gsc_pkg::TIMEOUT_TICKS - 20'h1;

    assign start_man = state == gsc_pkg::ST_IDLE && !auto_mode && hold_evt;
    assign start_auto = state == gsc_pkg::ST_IDLE && auto_mode && start_evt;
    assign cap_zero = !repl_press && !timeout_hit &&
        ((state == gsc_pkg::ST_WAIT_ZERO && hold_evt) ||
         (state == gsc_pkg::ST_AUTO_ZERO && tick &&
          step_cnt == gsc_pkg::AUTO_ZERO_TICKS - 20'h1));
    assign cap_span = !repl_press && !timeout_hit &&
        ((state == gsc_pkg::ST_SPAN_WAIT && hold_evt) ||
         (state == gsc_pkg::ST_AUTO_GAS && gas_seen && tick &&
          stable_cnt == gsc_pkg::STABLE_TICKS - 20'h1));

    // reed closure duration, saturates so each closure fires once
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            hold_cnt <= 20'h0;
            reed_q <= 1'b0;
        end else if (clk_en) begin
            reed_q <= reed;
            if (!reed) begin
                hold_cnt <= 20'h0;
            end else if (tick && hold_cnt != gsc_pkg::START_TICKS) begin
                hold_cnt <= hold_cnt + 20'h1;
            end
        end
    end

    // whole-run timeout
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            to_cnt <= 20'h0;
        end else if (clk_en) begin
            if (!timed || timeout_hit || repl_press) begin
                to_cnt <= 20'h0;
            end else if (tick) begin
                to_cnt <= to_cnt + 20'h1;
            end
        end
    end

    // automatic zero interval and span stability
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            step_cnt <= 20'h0;
            stable_cnt <= 20'h0;
            anchor <= 12'h000;
        end else if (clk_en) begin
            if (state != gsc_pkg::ST_AUTO_ZERO) begin
                step_cnt <= 20'h0;
            end else if (tick) begin
                step_cnt <= step_cnt + 20'h1;
            end
            if (state != gsc_pkg::ST_AUTO_GAS || !gas_seen || drift > gsc_pkg::STABLE_BAND) begin
                stable_cnt <= 20'h0;
                anchor <= sensor_value;
            end else if (tick && stable_cnt != gsc_pkg::STABLE_TICKS) begin
                stable_cnt <= stable_cnt + 20'h1;
            end
        end
    end

    // sequencer
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= gsc_pkg::ST_IDLE;
            repl_mode <= 1'b0;
        end else if (clk_en) begin
            if (repl_press) begin
                state <= gsc_pkg::ST_WAIT_ZERO;
                repl_mode <= 1'b1;
            end else if (timeout_hit) begin
                state <= gsc_pkg::ST_ABORT;
            end else begin
                unique case (state)
                    gsc_pkg::ST_IDLE: begin
                        if (start_man) begin
                            state <= gsc_pkg::ST_WAIT_ZERO;
                        end else if (start_auto) begin
                            state <= gsc_pkg::ST_AUTO_ZERO;
                        end
                    end
                    gsc_pkg::ST_WAIT_ZERO: begin
                        if (cap_zero) begin
                            state <= gsc_pkg::ST_SPAN_WAIT;
                        end
                    end
                    gsc_pkg::ST_SPAN_WAIT: begin
                        if (cap_span) begin
                            state <= gsc_pkg::ST_FINISH_WAIT;
                        end
                    end
                    gsc_pkg::ST_FINISH_WAIT: begin
                        if (reed_rise) begin
                            state <= gsc_pkg::ST_IDLE;
                            repl_mode <= 1'b0;
                        end
                    end
                    gsc_pkg::ST_AUTO_ZERO: begin
                        if (cap_zero) begin
                            state <= gsc_pkg::ST_AUTO_GAS;
                        end
                    end
                    gsc_pkg::ST_AUTO_GAS: begin
                        if (cap_span) begin
                            state <= gsc_pkg::ST_AUTO_FALL;
                        end
                    end
                    gsc_pkg::ST_AUTO_FALL: begin
                        if (below_low) begin
                            state <= gsc_pkg::ST_IDLE;
                        end
                    end
                    gsc_pkg::ST_ABORT: begin
                        // abort stays shown until the operator acknowledges
                        if (reed_rise) begin
                            state <= gsc_pkg::ST_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // coefficients and log; a captured reference follows its log entry by one cycle, a timeout restore lands with its entry
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            zero_ref <= gsc_pkg::ZERO_REF_RST;
            span_ref <= gsc_pkg::SPAN_REF_RST;
            saved_zero <= gsc_pkg::ZERO_REF_RST;
            saved_span <= gsc_pkg::SPAN_REF_RST;
            log_wr <= 1'b0;
            log_addr <= gsc_pkg::LOG_FIRST;
            log_kind <= gsc_pkg::GSC_LOG_ZERO;
            log_data <= 12'h000;
            log_ptr <= gsc_pkg::LOG_FIRST;
            pend_zero <= 1'b0;
            pend_span <= 1'b0;
        end else if (clk_en) begin
            log_wr <= 1'b0;
            pend_zero <= 1'b0;
            pend_span <= 1'b0;
            if (start_man || start_auto) begin
                saved_zero <= zero_ref;
                saved_span <= span_ref;
            end
            if (pend_zero) begin
                zero_ref <= log_data;
            end
            if (pend_span) begin
                span_ref <= log_data;
            end
            if (cap_zero || cap_span || timeout_hit) begin
                log_wr <= 1'b1;
                log_data <= sensor_value;
                pend_zero <= cap_zero;
                pend_span <= cap_span;
                if (repl_mode) begin
                    log_addr <= gsc_pkg::LOG_FIRST;
                end else begin
                    log_addr <= log_ptr;
                    log_ptr <= log_ptr + 3'h1;
                end
                if (timeout_hit) begin
                    log_kind <= gsc_pkg::GSC_LOG_ABORT;
                end else if (cap_zero) begin
                    log_kind <= gsc_pkg::GSC_LOG_ZERO;
                end else begin
                    log_kind <= gsc_pkg::GSC_LOG_SPAN;
                end
            end
            if (timeout_hit) begin
                zero_ref <= saved_zero;
                span_ref <= saved_span;
            end
        end
    end

    // indicators
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cal_led <= 1'b0;
            red_led <= 1'b0;
            fault_suppress <= 1'b0;
            cal_active <= 1'b0;
        end else if (clk_en) begin
            fault_suppress <= repl_mode;
            cal_active <= state != gsc_pkg::ST_IDLE && state != gsc_pkg::ST_ABORT;
            unique case (state)
                gsc_pkg::ST_IDLE: cal_led <= 1'b0;
                gsc_pkg::ST_WAIT_ZERO: cal_led <= blink;
                gsc_pkg::ST_SPAN_WAIT: cal_led <= gas_seen ? blink : 1'b1;
                gsc_pkg::ST_FINISH_WAIT: cal_led <= 1'b1;
                gsc_pkg::ST_AUTO_ZERO: cal_led <= blink;
                gsc_pkg::ST_AUTO_GAS: cal_led <= gas_seen ? blink : 1'b1;
                gsc_pkg::ST_AUTO_FALL: cal_led <= 1'b1;
                gsc_pkg::ST_ABORT: cal_led <= blink;
            endcase
            if (state == gsc_pkg::ST_ABORT) begin
                red_led <= blink;
            end else if (!reed) begin
                red_led <= 1'b0;
            end else if (!auto_mode && !repl_mode) begin
                red_led <= blink;
            end else begin
                red_led <= blink && hold_cnt < gsc_pkg::HOLD_TICKS;
            end
        end
    end

    // checks assume clk_en stays high
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    timeout_restore_a: assert property (clk_en && timeout_hit && !repl_press |=>
        zero_ref == saved_zero && span_ref == saved_span && state == gsc_pkg::ST_ABORT)
        else $error("timeout did not restore coefficients");
    abort_logged_a: assert property (clk_en && timeout_hit |=>
        log_wr && log_kind == gsc_pkg::GSC_LOG_ABORT)
        else $error("timeout not logged as aborted");
    abort_leds_a: assert property (clk_en && state == gsc_pkg::ST_ABORT |=>
        cal_led == $past(blink) && red_led == $past(blink))
        else $error("abort indication wrong");
    red_reed_a: assert property (clk_en && reed && !auto_mode && !repl_mode
        && state == gsc_pkg::ST_IDLE |=> red_led == $past(blink))
        else $error("red LED not following blink while reed closed");
    manual_start_a: assert property (clk_en && start_man && !repl_press |=>
        state == gsc_pkg::ST_WAIT_ZERO ##1 cal_led == $past(blink))
        else $error("manual start did not reach await-zero");
    zero_after_log_a: assert property (clk_en && cap_zero |=>
        log_wr && log_kind == gsc_pkg::GSC_LOG_ZERO && zero_ref == $past(zero_ref)
        ##1 zero_ref == $past(log_data))
        else $error("zero reference not updated after log entry");
    span_after_log_a: assert property (clk_en && cap_span && repl_mode |=>
        log_wr && log_addr == gsc_pkg::LOG_FIRST ##1 span_ref == $past(log_data))
        else $error("replacement span not logged first");
    repl_restart_a: assert property (clk_en && repl_press |=>
        state == gsc_pkg::ST_WAIT_ZERO && repl_mode ##1 fault_suppress)
        else $error("replacement press did not restart sequence");
    auto_stable_a: assert property (clk_en && cap_span && state == gsc_pkg::ST_AUTO_GAS
        |-> stable_cnt == gsc_pkg::STABLE_TICKS - 20'h1 && gas_seen)
        else $error("span captured before input stable");
    auto_finish_a: assert property (clk_en && state == gsc_pkg::ST_AUTO_FALL
        && !repl_press && !timeout_hit && below_low |=> state == gsc_pkg::ST_IDLE ##1 !cal_led)
        else $error("automatic run did not finish below threshold");

    manual_done_c: cover property (state == gsc_pkg::ST_FINISH_WAIT ##1 state == gsc_pkg::ST_IDLE);
    auto_done_c: cover property (state == gsc_pkg::ST_AUTO_FALL ##1 state == gsc_pkg::ST_IDLE);
    abort_seen_c: cover property (timeout_hit);
    repl_span_c: cover property (cap_span && repl_mode);

endmodule // gsc_calib_seq

/* tb/gsc_sensor_model.sv */
`timescale 1ns/10ps
module gsc_sensor_model (
    // clock
    input wire logic ref_clk,
    // switch pins and loop input
    output logic reed_closed_n,
    output logic repl_pressed_n,
    output logic [gsc_pkg::ADC_W-1:0] sensor_value
);
    // released switches sit at their pull-up level
    initial begin
        reed_closed_n = 1'b1;
        repl_pressed_n = 1'b1;
        sensor_value = 12'h000;
    end

    task automatic level(input logic [gsc_pkg::ADC_W-1:0] v);
        @(posedge ref_clk);
        #1 sensor_value = v;
    endtask

    task automatic press(input logic repl, input int cycles);
        @(posedge ref_clk);
        #1 if (repl) repl_pressed_n = 1'b0;
        else reed_closed_n = 1'b0;
        repeat (cycles) @(posedge ref_clk);
        #1 {reed_closed_n, repl_pressed_n} = 2'b11;
        // a reclose inside the debounce window would never be seen as a new closure
        repeat (100) @(posedge ref_clk);
    endtask
endmodule // gsc_sensor_model

/* tb/gsc_calib_seq_tb_top.sv */
`timescale 1ns/10ps
module gsc_calib_seq_tb_top;
    localparam int TK = 2;
    localparam int HC = 3060 * TK;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic auto_mode = 1'b0;
    logic reed_closed_n, repl_pressed_n, cal_led, red_led, fault_suppress, cal_active, log_wr;
    logic [11:0] sensor_value, zero_ref, span_ref, log_data;
    logic [2:0] log_addr, addr;
    gsc_pkg::gsc_log_kind_t log_kind;
    logic red_hi = 1'b0;
    int miscompares = 0;
    int n_checks = 0;

    gsc_sensor_model gsc_sensor_model_inst (.ref_clk(ref_clk), .reed_closed_n(reed_closed_n),
        .repl_pressed_n(repl_pressed_n), .sensor_value(sensor_value));
    gsc_calib_seq #(.TICK_CYCLES(TK)) gsc_calib_seq_inst (.ref_clk(ref_clk), .reset(reset),
        .clk_en(clk_en), .reed_closed_n(reed_closed_n), .repl_pressed_n(repl_pressed_n),
        .auto_mode(auto_mode), .sensor_value(sensor_value), .cal_led(cal_led),
        .red_led(red_led), .fault_suppress(fault_suppress), .cal_active(cal_active),
        .zero_ref(zero_ref), .span_ref(span_ref), .log_wr(log_wr), .log_addr(log_addr),
        .log_kind(log_kind), .log_data(log_data));

    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (!reed_closed_n && red_led === 1'b1) red_hi <= 1'b1;

    task automatic end_of_test();
        if (miscompares == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask

    task automatic do_reset();
        @(posedge ref_clk);
        #1 reset = 1'b1;
        repeat (5) @(posedge ref_clk);
        #1 reset = 1'b0;
    endtask

    // log_wr stands one cycle, so it is sampled every cycle
    task automatic wait_log(input gsc_pkg::gsc_log_kind_t k, input logic [11:0] d);
        int n;
        n = 0;
        while (log_wr !== 1'b1 && n < 9000 * TK) begin
            settle(1);
            n++;
        end
        addr = log_addr;
        chk({11'h0, log_wr}, 12'h001);
        chk({10'h0, log_kind}, {10'h0, k});
        chk(log_data, d);
    endtask

    task automatic seen_blink();
        logic s0, s1;
        s0 = 1'b0;
        s1 = 1'b0;
        repeat (600 * TK) begin
            settle(1);
            s1 |= (cal_led === 1'b1);
            s0 |= (cal_led === 1'b0);
        end
        chk({11'h0, s0 & s1}, 12'h001);
    endtask

    task automatic capture(input gsc_pkg::gsc_log_kind_t k, input logic [11:0] d, input int c);
        gsc_sensor_model_inst.level(d);
        fork
            gsc_sensor_model_inst.press(1'b0, c);
            wait_log(k, d);
        join
        settle(1);
    endtask

    task automatic test_manual();
        gsc_sensor_model_inst.press(1'b0, HC);
        settle(1);
        chk({11'h0, cal_active}, 12'h001);
        chk({11'h0, red_hi}, 12'h001);
        capture(gsc_pkg::GSC_LOG_ZERO, 12'h123, HC);
        chk(zero_ref, 12'h123);
        chk({11'h0, cal_led}, 12'h001);
        gsc_sensor_model_inst.level(12'h800);
        seen_blink();
        capture(gsc_pkg::GSC_LOG_SPAN, 12'h800, HC);
        chk(span_ref, 12'h800);
        chk({11'h0, cal_led}, 12'h001);
        gsc_sensor_model_inst.level(12'h123);
        gsc_sensor_model_inst.press(1'b0, 40 * TK);
        settle(20 * TK);
        chk({10'h0, cal_led, cal_active}, 12'h000);
    endtask

    task automatic test_repl();
        gsc_sensor_model_inst.press(1'b1, 40 * TK);
        settle(40 * TK);
        chk({10'h0, fault_suppress, cal_active}, 12'h003);
        seen_blink();
        capture(gsc_pkg::GSC_LOG_ZERO, 12'h050, HC);
        chk({9'h0, addr}, {9'h0, gsc_pkg::LOG_FIRST});
        chk(zero_ref, 12'h050);
        capture(gsc_pkg::GSC_LOG_SPAN, 12'h700, HC);
        chk({9'h0, addr}, {9'h0, gsc_pkg::LOG_FIRST});
        chk(span_ref, 12'h700);
        gsc_sensor_model_inst.press(1'b1, 40 * TK);
        settle(40 * TK);
        seen_blink();
        chk({11'h0, fault_suppress}, 12'h001);
        do_reset();
        settle(1);
        chk({10'h0, fault_suppress, cal_active}, 12'h000);
    endtask

    task automatic test_auto();
        @(posedge ref_clk);
        #1 auto_mode = 1'b1;
        capture(gsc_pkg::GSC_LOG_ZERO, 12'h020, 4060 * TK);
        chk(zero_ref, 12'h020);
        chk({11'h0, cal_led}, 12'h001);
    endtask

    initial begin
        do_reset();
        settle(1);
        chk(zero_ref, 12'h000);
        chk(span_ref, 12'hFFF);
        test_manual();
        test_repl();
        test_auto();
        end_of_test();
    end

    // whole run is near 52000 cycles
    initial begin
        repeat (100000) @(posedge ref_clk);
        miscompares++;
        end_of_test();
    end
endmodule // gsc_calib_seq_tb_top
